// ---- design/sck_pkg.sv ----
// Purpose: shared constants and types for the sample clock control block
// Assumes: one 100 MHz system clock, synchronous active-low reset
// Notes: field positions follow the two synthesizer control words
package sck_pkg;

  // ==========================================================
  // timing
  // ==========================================================
  localparam int SCK_CLK_PERIOD_NS = 10;
  // quiet time on the old path before the mux flips
  localparam int SCK_SWITCH_GAP_NS = 40;
  localparam int SCK_SWITCH_GAP_CYC =
    (SCK_SWITCH_GAP_NS + SCK_CLK_PERIOD_NS - 1) / SCK_CLK_PERIOD_NS;

  // ==========================================================
  // field layouts of synth_control_word_a
  // ==========================================================
  localparam int SCK_A_PATH_BIT = 0;
  localparam int SCK_A_CP_LSB = 1;
  localparam int SCK_A_PRESC_LSB = 3;
  localparam int SCK_A_MDIV_LSB = 6;
  // synth_control_word_b
  localparam int SCK_B_SLEEP_BIT = 0;
  localparam int SCK_B_VCO_LSB = 1;

  // ==========================================================
  // encodings and reset values
  // ==========================================================
  localparam logic [1:0] SCK_CP_SINGLE = 2'h1;
  localparam logic [1:0] SCK_CP_DOUBLE = 2'h3;
  localparam logic [2:0] SCK_PRESC_RESET = 3'h7;
  localparam logic [7:0] SCK_MDIV_RESET = 8'h04;
  localparam logic [5:0] SCK_VCO_RESET = 6'h00;
  localparam logic [13:0] SCK_WORD_A_RESET = 14'h0103 | 14'h0038;
  localparam logic [6:0] SCK_WORD_B_RESET = 7'h01;

  typedef enum logic [1:0] {
    SCK_ST_DIRECT = 2'b00,
    SCK_ST_HOLD_TO_PLL = 2'b01,
    SCK_ST_SYNTH = 2'b10,
    SCK_ST_HOLD_TO_DIR = 2'b11
  } sck_state_t;

  // decoded synthesizer settings seen by the analog loop
  typedef struct packed {
    logic sleep;
    logic [1:0] chargePump;
    logic [2:0] prescale;
    logic [5:0] vcoTune;
    logic [7:0] mDivide;
  } sck_synth_cfg_t;

  typedef struct packed {
    logic pathSynth;
    logic switching;
    logic ratioOk;
    logic loopFilterOk;
  } sck_status_t;

endpackage

// ---- design/sck_strobe_div.sv ----
// Purpose: N divider that produces the internal output strobe
// Assumes: runs on the synthesized clock reference tick
// Notes: strobe is one cycle wide, once every divideN ticks
`timescale 1ns/1ns
module sck_strobe_div #(
  parameter int WIDTH = 8
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic enable,
  input wire logic tick,
  input wire logic [WIDTH-1:0] divideN,
  output logic strobe
);
  logic [WIDTH-1:0] count_reg;

  initial begin
    if (WIDTH < 2) $error("sck_strobe_div: WIDTH below 2");
  end

  // divide by zero or one both give a strobe every tick
  always_ff @(posedge sys_clk) begin
    if (!rst_b || !enable) begin
      count_reg <= '0;
    end else if (tick) begin
      if (count_reg + WIDTH'(1) >= divideN) begin
        count_reg <= '0;
      end else begin
        count_reg <= count_reg + WIDTH'(1);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b || !enable) begin
      strobe <= 1'b0;
    end else begin
      strobe <= tick && (count_reg + WIDTH'(1) >= divideN);
    end
  end
endmodule // sck_strobe_div

// ---- design/sck_sample_clock_ctrl.sv ----
// Purpose: sample-rate clock path control, synthesizer settings and strobe
// Assumes: clock edges are modelled as enable ticks in the sys_clk domain
// Notes: analog loop lives outside; this drives its settings and the mux
//
// Summary of operation
// [R1] path select clear: converter clock input drives the sample clock directly.
// [R2] sleep set: PLL and VCO asleep; bypass expects sleep set.
// [R3] path select set: PLL output becomes the sample clock.
// [R4] sleep clear enables PLL and VCO; PLL mode needs path set too.
// [R5] PLL mode multiplies the reference up to a faster sample clock.
// [R6] software picks prescaler so prescale times sample rate is 3.3-4.0 GHz.
// [R7] 3-bit prescaler code equals its divide value.
// [R8] 6-bit coarse tune shifts the VCO centre frequency.
// [R9] 8-bit plain binary M divider sets detector and pump rate.
// [R10] software keeps detector frequency below 155 MHz.
// [R11] software keeps prescaler times M within 24 to 480.
// [R12] above ratio 120 use external filter or double charge pump.
// [R13] pump code 01 single current, 11 double current.
// [R14] PLL mode makes the output strobe from the N divider.
// [R15] software sets detector rate equal to wanted strobe rate.
// [R16] strobe rate is sample rate over n times interpolation times 8.
// [R17] the sample clock feeds converter cores and core logic only.
// [R18] path changes produce no runt pulses on the sample clock.
`timescale 1ns/1ns
module sck_sample_clock_ctrl #(
  parameter int N_WIDTH = 8,
  parameter int RATIO_MIN = 24,
  parameter int RATIO_MAX = 480,
  parameter int RATIO_INT_FILTER = 120
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic converter_clock_input,
  input wire logic synth_clock_tick,
  input wire logic [13:0] synth_control_word_a,
  input wire logic [6:0] synth_control_word_b,
  input wire logic [N_WIDTH-1:0] nDivide,
  output sck_pkg::sck_synth_cfg_t synthCfg,
  output logic sampleClockTick,
  output logic output_strobe,
  output sck_pkg::sck_status_t status
);
  import sck_pkg::*;

  initial begin
    if (N_WIDTH < 2 || N_WIDTH > 16) $error("sck_sample_clock_ctrl: bad N_WIDTH");
    if (RATIO_MIN > RATIO_MAX) $error("sck_sample_clock_ctrl: bad ratio limits");
  end

  // ==========================================================
  // pin input synchroniser: three stages, change on 2nd==3rd
  // ==========================================================
  logic [2:0] inSync_reg;
  logic inLevel_reg;
  logic inLevelPrev_reg;
  logic directTick;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      inSync_reg <= 3'h0;
    end else begin
      inSync_reg <= {inSync_reg[1:0], converter_clock_input};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      inLevel_reg <= 1'b0;
      inLevelPrev_reg <= 1'b0;
    end else begin
      if (inSync_reg[1] == inSync_reg[2]) begin
        inLevel_reg <= inSync_reg[2];
      end
      inLevelPrev_reg <= inLevel_reg;
    end
  end

  assign directTick = inLevel_reg && !inLevelPrev_reg;

  // ==========================================================
  // settings registers
  // ==========================================================
  logic pathSel;
  logic sleepSel;
  logic [1:0] cpCode;
  logic [2:0] presc;
  logic [7:0] mDiv;
  logic [5:0] vcoTune;
  logic [10:0] ratio;
  sck_synth_cfg_t synthCfg_reg;

  assign pathSel = synth_control_word_a[SCK_A_PATH_BIT];
  assign cpCode = synth_control_word_a[SCK_A_CP_LSB +: 2];
  assign presc = synth_control_word_a[SCK_A_PRESC_LSB +: 3];
  assign mDiv = synth_control_word_a[SCK_A_MDIV_LSB +: 8];
  assign sleepSel = synth_control_word_b[SCK_B_SLEEP_BIT];
  assign vcoTune = synth_control_word_b[SCK_B_VCO_LSB +: 6];
  assign ratio = 11'(presc) * 11'(mDiv);

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      synthCfg_reg <= '{sleep: 1'b1, chargePump: SCK_CP_SINGLE, prescale: SCK_PRESC_RESET,
                        vcoTune: SCK_VCO_RESET, mDivide: SCK_MDIV_RESET};
    end else begin
      synthCfg_reg.sleep <= sleepSel; // R2 R4
      // unknown pump codes fall back to single current
      synthCfg_reg.chargePump <= (cpCode == SCK_CP_DOUBLE) ? SCK_CP_DOUBLE : SCK_CP_SINGLE; // R13
      synthCfg_reg.prescale <= presc; // R7
      synthCfg_reg.vcoTune <= vcoTune; // R8
      synthCfg_reg.mDivide <= mDiv; // R9
    end
  end

  assign synthCfg = synthCfg_reg;

  // ==========================================================
  // glitch-free path switch
  // ==========================================================
  sck_state_t state_reg;
  sck_state_t state_next;
  logic [7:0] gap_reg;
  logic synthRunning;
  logic synthTick;

  // the synthesized tick only counts while the loop is awake
  assign synthRunning = pathSel && !sleepSel; // R4 R5
  assign synthTick = synth_clock_tick && !synthCfg_reg.sleep;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SCK_ST_DIRECT: begin
        if (synthRunning) state_next = SCK_ST_HOLD_TO_PLL;
      end
      SCK_ST_HOLD_TO_PLL: begin
        if (!synthRunning) state_next = SCK_ST_DIRECT;
        else if (gap_reg == 8'(SCK_SWITCH_GAP_CYC - 1)) state_next = SCK_ST_SYNTH;
      end
      SCK_ST_SYNTH: begin
        if (!synthRunning) state_next = SCK_ST_HOLD_TO_DIR;
      end
      SCK_ST_HOLD_TO_DIR: begin
        if (gap_reg == 8'(SCK_SWITCH_GAP_CYC - 1)) state_next = SCK_ST_DIRECT;
      end
      default: state_next = SCK_ST_DIRECT;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state_reg <= SCK_ST_DIRECT;
    end else begin
      state_reg <= state_next;
    end
  end

  // both paths held quiet for the gap, so no partial period escapes
  always_ff @(posedge sys_clk) begin
    if (!rst_b || state_next != state_reg) begin
      gap_reg <= 8'h00;
    end else if (state_reg == SCK_ST_HOLD_TO_PLL || state_reg == SCK_ST_HOLD_TO_DIR) begin
      gap_reg <= gap_reg + 8'h01; // R18
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      sampleClockTick <= 1'b0;
    end else begin
      case (state_reg)
        SCK_ST_DIRECT: sampleClockTick <= directTick; // R1 R17
        SCK_ST_SYNTH: sampleClockTick <= synthTick; // R3 R5 R17
        default: sampleClockTick <= 1'b0; // R18
      endcase
    end
  end

  // ==========================================================
  // internal output strobe from N divider
  // ==========================================================
  sck_strobe_div #(
    .WIDTH(N_WIDTH)
  ) u_strobe_div (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .enable(state_reg == SCK_ST_SYNTH), // R14
    .tick(synthTick),
    .divideN(nDivide),
    .strobe(output_strobe)
  );

  // ==========================================================
  // status
  // ==========================================================
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      status <= '0;
    end else begin
      status.pathSynth <= (state_reg == SCK_ST_SYNTH);
      status.switching <= state_reg == SCK_ST_HOLD_TO_PLL || state_reg == SCK_ST_HOLD_TO_DIR;
      status.ratioOk <= ratio >= 11'(RATIO_MIN) && ratio <= 11'(RATIO_MAX); // R11
      status.loopFilterOk <= ratio <= 11'(RATIO_INT_FILTER) || cpCode == SCK_CP_DOUBLE; // R12
    end
  end

  // ==========================================================
  // checks
  // ==========================================================
  sequence seqLeaveSynth;
    state_reg == SCK_ST_SYNTH ##1 state_reg == SCK_ST_HOLD_TO_DIR;
  endsequence

  AST_NO_STROBE_DIRECT: assert property (@(posedge sys_clk) disable iff (!rst_b) // R14
    state_reg == SCK_ST_DIRECT |=> !output_strobe)
    else $error("strobe seen on direct path");
  AST_DIRECT_FOLLOWS: assert property (@(posedge sys_clk) disable iff (!rst_b) // R1
    state_reg == SCK_ST_DIRECT |=> sampleClockTick == $past(directTick))
    else $error("direct tick not passed");
  AST_SYNTH_FOLLOWS: assert property (@(posedge sys_clk) disable iff (!rst_b) // R3
    state_reg == SCK_ST_SYNTH |=> sampleClockTick == $past(synthTick))
    else $error("synth tick not passed");
  AST_QUIET_GAP: assert property (@(posedge sys_clk) disable iff (!rst_b) // R18
    seqLeaveSynth |-> ##1 !sampleClockTick [*4])
    else $error("tick during path switch");
  AST_SLEEP_FOLLOWS: assert property (@(posedge sys_clk) disable iff (!rst_b) // R2
    sleepSel |=> synthCfg.sleep)
    else $error("sleep not applied");
  AST_CP_ENCODE: assert property (@(posedge sys_clk) disable iff (!rst_b) // R13
    cpCode == SCK_CP_DOUBLE |=> synthCfg.chargePump == SCK_CP_DOUBLE)
    else $error("double pump not selected");
  AST_PRESC_CODE: assert property (@(posedge sys_clk) disable iff (!rst_b) // R7
    1'b1 |=> synthCfg.prescale == $past(presc))
    else $error("prescale mismatch");
  AST_MDIV_CODE: assert property (@(posedge sys_clk) disable iff (!rst_b) // R9
    1'b1 |=> synthCfg.mDivide == $past(mDiv) && synthCfg.vcoTune == $past(vcoTune)) // R8
    else $error("divider or tune mismatch");
  AST_REACH_SYNTH: assert property (@(posedge sys_clk) disable iff (!rst_b) // R4
    state_reg == SCK_ST_DIRECT ##1 synthRunning [*6] |-> state_reg == SCK_ST_SYNTH)
    else $error("synth path not reached");
endmodule // sck_sample_clock_ctrl

// ---- tb/sck_clock_source.sv ----
// Purpose: far-side clock source: reference pin and synthesized clock ticks
// Assumes: sys_clk at 100 MHz
// Notes: reference toggles on even ns only, never on a rising sys_clk edge
`timescale 1ns/1ns
module sck_clock_source (
  input wire logic sys_clk,
  input wire logic refRun,
  input wire logic synthRun,
  output logic converter_clock_input,
  output logic synth_clock_tick
);
  int tickDiv = 0;
  initial converter_clock_input = 1'b0;
  initial synth_clock_tick = 1'b0;
  // ==========================================================
  // reference, 44 ns period, parked low when stopped
  // ==========================================================
  // an edge-aligned toggle would race the sampling flops of both sides
  always begin
    #22;
    converter_clock_input = refRun ? ~converter_clock_input : 1'b0;
  end
  // synthesized clock seen as one tick every third cycle
  always @(posedge sys_clk) begin
    tickDiv <= (tickDiv == 2) ? 0 : tickDiv + 1;
    synth_clock_tick <= #1 synthRun && (tickDiv == 2);
  end
endmodule // sck_clock_source

// ---- tb/sck_sample_clock_ctrl_tb.sv ----
// Purpose: self-checking bench for the sample clock control block
// Assumes: inputs driven 1 ns after the rising edge
// Notes: tick counts compared with a tolerance of one for pipeline skew
`timescale 1ns/1ns
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; \
  $display("ERROR t=%0t got %0h exp %0h", $time, a, b); end end
module sck_sample_clock_ctrl_tb;
  import sck_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic refRun = 1'b1;
  logic synthRun = 1'b1;
  logic convClk, synthTick, sampleClockTick, strobe;
  logic [13:0] wordA = 14'h013A;
  logic [6:0] wordB = 7'h01;
  logic [7:0] nDivide = 8'h04;
  sck_synth_cfg_t synthCfg;
  sck_status_t status;
  logic countOn = 1'b0;
  logic pinPrev = 1'b0;
  int nTick, nStrobe, nSynth, nRef, nSwitch, miscompares, comparisons, cycles;
  always #5 sys_clk = ~sys_clk;
  sck_clock_source src (.sys_clk(sys_clk), .refRun(refRun), .synthRun(synthRun),
    .converter_clock_input(convClk), .synth_clock_tick(synthTick));
  sck_sample_clock_ctrl dut (.sys_clk(sys_clk), .rst_b(rst_b),
    .converter_clock_input(convClk), .synth_clock_tick(synthTick),
    .synth_control_word_a(wordA), .synth_control_word_b(wordB), .nDivide(nDivide),
    .synthCfg(synthCfg), .sampleClockTick(sampleClockTick), .output_strobe(strobe),
    .status(status));
  // ==========================================================
  // event counters and hang guard
  // ==========================================================
  always @(posedge sys_clk) begin
    cycles++;
    pinPrev <= convClk;
    if (countOn) begin
      nTick += sampleClockTick;
      nStrobe += strobe;
      nSynth += synthTick;
      nRef += (convClk && !pinPrev);
      nSwitch += status.switching;
    end
    if (cycles == 4000) begin
      miscompares++;
      summarize();
    end
  end
  task automatic summarize();
    $display("counts: comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic window(input int n);
    #1;
    {nTick, nStrobe, nSynth, nRef, nSwitch} = '0;
    countOn = 1'b1;
    repeat (n) @(posedge sys_clk);
    #1;
    countOn = 1'b0;
  endtask
  task automatic setWords(input logic [13:0] a, input logic [6:0] b);
    @(posedge sys_clk);
    #1;
    wordA = a;
    wordB = b;
  endtask
  task automatic near(input int a, input int b);
    `CHK((a - b <= 1) && (b - a <= 1), 1'b1)
  endtask
  // gap check: the old path's last tick is still in flight for two edges
  task automatic gapQuiet();
    repeat (2) @(posedge sys_clk);
    window(4);
    `CHK(nTick, 0)
    `CHK(nSwitch > 0, 1'b1)
  endtask
  int pm[4][3] = '{'{3, 8, 1}, '{3, 7, 0}, '{4, 120, 1}, '{4, 121, 0}};
  initial begin
    repeat (16) @(posedge sys_clk);
    #1;
    `CHK(synthCfg, sck_synth_cfg_t'({1'b1, SCK_CP_SINGLE, SCK_PRESC_RESET,
      SCK_VCO_RESET, SCK_MDIV_RESET}))
    rst_b = 1'b1;
    repeat (10) @(posedge sys_clk);
    window(200);
    near(nTick, nRef);
    `CHK(nStrobe, 0)
    $display("test bypass done");
    setWords(14'h013B, 7'h01);
    repeat (8) @(posedge sys_clk);
    window(200);
    near(nTick, nRef);
    `CHK(synthCfg.sleep, 1'b1)
    $display("test path without wake done");
    // prescale 7, M 4: ratio 28, inside the loop limits
    setWords(14'h013B, 7'h00);
    gapQuiet();
    // reference parked: the synthesized path must not lean on the pin
    refRun = 1'b0;
    repeat (4) @(posedge sys_clk);
    window(240);
    near(nTick, nSynth);
    near(nStrobe, nSynth / 4);
    `CHK(status.pathSynth, 1'b1)
    `CHK(synthCfg.sleep, 1'b0)
    // loop ticks stopped, reference running: no direct tick may leak
    refRun = 1'b1;
    synthRun = 1'b0;
    repeat (3) @(posedge sys_clk);
    window(30);
    `CHK(nTick, 0)
    `CHK(nStrobe, 0)
    synthRun = 1'b1;
    $display("test synth done");
    setWords(14'h013A, 7'h01);
    gapQuiet();
    repeat (6) @(posedge sys_clk);
    window(200);
    near(nTick, nRef);
    `CHK(nStrobe, 0)
    $display("test back to bypass done");
    for (int i = 0; i < 4; i++) begin
      setWords({8'h20, 3'h7, 2'(i), 1'b0}, 7'h55);
      repeat (3) @(posedge sys_clk);
      #1;
      `CHK(synthCfg, sck_synth_cfg_t'({1'b1, (i == 3) ? 2'h3 : 2'h1, 3'h7, 6'h2A,
        8'h20}))
      `CHK(status.loopFilterOk, 1'(i == 3))
    end
    for (int i = 0; i < 4; i++) begin
      setWords({8'(pm[i][1]), 3'(pm[i][0]), 2'h1, 1'b0}, 7'h01);
      repeat (3) @(posedge sys_clk);
      #1;
      `CHK(synthCfg.prescale, 3'(pm[i][0]))
      `CHK(status.ratioOk, 1'(pm[i][2]))
    end
    $display("test fields done");
    summarize();
  end
endmodule // sck_sample_clock_ctrl_tb
